// [common/nfr_defines.svh]
// Purpose: constants of the feature register bank
// Assumes: one-byte feature addresses, 8-bit registers
// Notes:   offsets, field positions, reset values and timing counts
`ifndef NFR_DEFINES_SVH
`define NFR_DEFINES_SVH

// ----------------------------------------------------------------
// feature addresses
// ----------------------------------------------------------------
`define NFR_ADR_SEC0       8'h80
`define NFR_ADR_SEC1       8'h84
`define NFR_ADR_SEC2       8'h88
`define NFR_ADR_SEC3       8'h8c
`define NFR_ADR_PROTECT    8'ha0
`define NFR_ADR_CONFIG     8'hb0
`define NFR_ADR_STATUS     8'hc0

// ----------------------------------------------------------------
// protection register fields
// ----------------------------------------------------------------
`define NFR_PR_LOCKWP      7
`define NFR_PR_BP_HI       6
`define NFR_PR_BP_LO       3
`define NFR_PR_TB          2
`define NFR_PR_PLOCK       0
`define NFR_PR_WMASK       8'hfd

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define NFR_CF_OTPL        7
`define NFR_CF_OTPE        6
`define NFR_CF_ECCE        4
`define NFR_CF_DRV_HI      2
`define NFR_CF_DRV_LO      1
`define NFR_CF_QE          0
`define NFR_CF_WMASK       8'h57

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define NFR_ST_ECC_HI      5
`define NFR_ST_ECC_LO      4
`define NFR_ST_PFAIL       3
`define NFR_ST_EFAIL       2
`define NFR_ST_WEL         1
`define NFR_ST_OIP         0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NFR_RST_BP         4'hf
`define NFR_RST_TB         1'h1
`define NFR_RST_DRV        2'h0
`define NFR_RST_ECCE       1'h1

// ----------------------------------------------------------------
// timing: soft reset busy time
// ----------------------------------------------------------------
`define NFR_SRST_NS        200
`define NFR_CLK_NS         20
`define NFR_SRST_CYC       ((`NFR_SRST_NS + `NFR_CLK_NS - 1) / `NFR_CLK_NS)

`endif

// [common/nfr_pkg.sv]
// Purpose: types of the feature register bank
// Assumes: nothing beyond the defines header
// Notes:   the packed structs carry grouped signals and module state
package nfr_pkg;

   // ----------------------------------------------------------------
   // feature access request from the command decoder
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       rd;    // read-feature strobe
      logic       wr;    // write-feature strobe
      logic [7:0] adr;   // feature address
      logic [7:0] wdat;  // write data
   } nfr_feat_req_type;

   // ----------------------------------------------------------------
   // array operation events from the core
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        wr_en;     // write enable instruction
      logic        wr_dis;    // write disable instruction
      logic        prog;      // program execute start
      logic        erase;     // block erase start
      logic        page_rd;   // page data read start
      logic        soft_rst;  // soft reset command
      logic        busy;      // array operation running
      logic        pfail;     // program failed
      logic        efail;     // erase failed
      logic        ecc_vld;   // ecc result valid
      logic [1:0]  ecc_sum;   // summary ecc result
      logic [15:0] ecc_sec;   // four sector nibbles
   } nfr_core_ev_type;

   // ----------------------------------------------------------------
   // soft reset timer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      NFR_IDLE = 2'b00,
      NFR_BUSY = 2'b01
   } nfr_srst_type;

   typedef struct packed {
      nfr_srst_type st;
      logic [7:0]   cnt;
   } nfr_srst_state_type;

   typedef struct packed {
      logic lo;
      logic hi;
      logic prot;
   } nfr_bpd_state_type;

endpackage : nfr_pkg

// [src/nfr_blk_decode.sv]
// Purpose: block protect decode for a program or erase target
// Assumes: 11-bit block address, result registered one cycle
// Notes:   the region sits at one end of the array, so one compare is enough
`include "nfr_defines.svh"
module nfr_blk_decode
   import nfr_pkg::*;
(
   input  wire logic        mclk,  // system clock
   input  wire logic        rst,   // sync reset
   input  wire logic [3:0]  code,  // block protect code
   input  wire logic        tb,    // top/bottom select
   input  wire logic [10:0] blk,   // target block
   output logic             prot   // block is protected
);

   nfr_bpd_state_type s_ff;   // registered decode
   nfr_bpd_state_type nxt_s;  // next decode
   logic [11:0]       span;   // number of protected blocks, codes 1..11 only

   // ----------------------------------------------------------------
   // decode: codes 1..11 give 2**(code-1) blocks
   // ----------------------------------------------------------------
   always_comb begin
      span = 12'h000;
      nxt_s = '0;
      if (code[3:2] == 2'b11) begin
         nxt_s.prot = 1'b1; // whole array
      end else if (code != 4'h0) begin
         span = 12'(12'h001 << (code - 4'h1));
         if (tb) begin
            nxt_s.lo   = ({1'b0, blk} < span); // lowest blocks
            nxt_s.prot = nxt_s.lo;
         end else begin
            nxt_s.hi   = ({1'b0, blk} >= (12'h800 - span));
            nxt_s.prot = nxt_s.hi;
         end
      end
      // code 0 protects nothing
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prot = s_ff.prot;

endmodule : nfr_blk_decode

// [src/nfr_feature_regs.sv]
// Purpose: feature register bank with write protection
// Assumes: command decoder delivers strobes on mclk
// Notes:   rst stands for power-up; soft reset is an event input
//          protect writes obey lock bits, quad mode, pin
//          program/erase answer two cycles after the pulse
`include "nfr_defines.svh"

module nfr_feature_regs
   import nfr_pkg::*;
(
   input  wire logic             mclk,         // system clock
   input  wire logic             rst,          // power-up reset
   input  wire nfr_feat_req_type req,          // feature access
   input  wire nfr_core_ev_type  ev,           // core events
   input  wire logic [10:0]      tgt_blk,      // program/erase block
   input  wire logic             otp_locked,   // otp area locked
   input  wire logic             wp_n,         // write-protect pin
   output logic [7:0]            rd_data,      // feature read data
   output logic                  rd_vld,       // read data valid
   output logic                  op_go,        // program/erase allowed
   output logic                  op_block,     // program/erase dropped
   output logic                  quad_mode,    // pins act as data
   output logic [1:0]            drive_sel,    // drive strength
   output logic                  ecc_on,       // ecc enabled
   output logic                  otp_access    // otp access mode
);

   // ----------------------------------------------------------------
   // module state
   // ----------------------------------------------------------------
   // one struct holds all state but the pin synchroniser
   typedef struct packed {
      logic       lock_write_protect_bit; // protect register lock
      logic [3:0] block_protect_code;     // protect code
      logic       top_bottom_select;      // region side
      logic       power_lock_bit;         // lock until power cycle
      logic       otp_lock;               // otp locked
      logic       otp_en;                 // otp access
      logic       ecc_en;                 // ecc enable
      logic [1:0] drive_strength_field;   // drive strength
      logic       quad_enable_bit;        // quad mode
      logic [1:0] ecc_result_bits;        // summary ecc
      logic       pfail;                  // program fail
      logic       efail;                  // erase fail
      logic       write_enable_latch;     // write enable
      logic [15:0] sec_err;               // sector error nibbles
      logic       init;                   // otp strap pending
      logic [7:0] rdat;                   // read data
      logic       rvld;                   // read valid
      logic       pend;                   // op awaiting decode
      logic       pend_pg;                // pending is program
      logic       go;                     // op accepted
      logic       blkd;                   // op refused
   } nfr_regs_state_type;

   nfr_regs_state_type s_ff;   // registered state
   nfr_regs_state_type nxt_s;  // next state

   // signals between the processes
   logic [1:0] wp_sync_ff;  // pin synchroniser
   logic       srst_busy;   // soft reset running
   logic       blk_prot;    // target block protected
   logic       prot_wr_ok;  // protect register writable
   logic [7:0] rmux;        // read mux

   // ----------------------------------------------------------------
   // sub blocks
   // ----------------------------------------------------------------
   // busy bit after a soft reset
   nfr_srst_timer u_srst (
      .mclk  (mclk),
      .rst   (rst),
      .start (ev.soft_rst),
      .busy  (srst_busy)
   );

   // registered block decode
   nfr_blk_decode u_bpd (
      .mclk (mclk),
      .rst  (rst),
      .code (s_ff.block_protect_code),
      .tb   (s_ff.top_bottom_select),
      .blk  (tgt_blk),
      .prot (blk_prot)
   );

   // ----------------------------------------------------------------
   // write-protect pin synchroniser
   // ----------------------------------------------------------------
   // resets as a released pin
   // only the second flop is read
   always_ff @(posedge mclk) begin
      if (rst) begin
         wp_sync_ff <= 2'b11;
      end else begin
         wp_sync_ff <= {wp_sync_ff[0], wp_n};
      end
   end

   // ----------------------------------------------------------------
   // protect register write permission
   // ----------------------------------------------------------------
   // power lock, then quad mode, then lock bit and pin
   always_comb begin
      if (s_ff.power_lock_bit) begin
         prot_wr_ok = 1'b0;
      end else if (s_ff.quad_enable_bit) begin
         prot_wr_ok = 1'b1;
      end else begin
         // locked: bit set and pin low
         prot_wr_ok = !s_ff.lock_write_protect_bit ||
                      wp_sync_ff[1];
      end
   end

   // ----------------------------------------------------------------
   // read mux, reserved bits zero
   // ----------------------------------------------------------------
   // read only with a strobe
   // result lands in the read register
   always_comb begin
      rmux = 8'h00;
      case (req.adr)
         `NFR_ADR_PROTECT: begin
            rmux[`NFR_PR_LOCKWP]              = s_ff.lock_write_protect_bit;
            rmux[`NFR_PR_BP_HI:`NFR_PR_BP_LO] = s_ff.block_protect_code;
            rmux[`NFR_PR_TB]                  = s_ff.top_bottom_select;
            rmux[`NFR_PR_PLOCK]               = s_ff.power_lock_bit;
         end
         `NFR_ADR_CONFIG: begin
            rmux[`NFR_CF_OTPL]                  = s_ff.otp_lock;
            rmux[`NFR_CF_OTPE]                  = s_ff.otp_en;
            rmux[`NFR_CF_ECCE]                  = s_ff.ecc_en;
            rmux[`NFR_CF_DRV_HI:`NFR_CF_DRV_LO] = s_ff.drive_strength_field;
            rmux[`NFR_CF_QE]                    = s_ff.quad_enable_bit;
         end
         `NFR_ADR_STATUS: begin
            rmux[`NFR_ST_ECC_HI:`NFR_ST_ECC_LO] = s_ff.ecc_result_bits;
            rmux[`NFR_ST_PFAIL]                 = s_ff.pfail;
            rmux[`NFR_ST_EFAIL]                 = s_ff.efail;
            rmux[`NFR_ST_WEL]                   = s_ff.write_enable_latch;
            // busy from timer or array op
            rmux[`NFR_ST_OIP]                   = srst_busy || ev.busy;
         end
         // sector: index above error nibble
         `NFR_ADR_SEC0: rmux = {4'h0, s_ff.sec_err[3:0]};
         `NFR_ADR_SEC1: rmux = {4'h1, s_ff.sec_err[7:4]};
         `NFR_ADR_SEC2: rmux = {4'h2, s_ff.sec_err[11:8]};
         `NFR_ADR_SEC3: rmux = {4'h3, s_ff.sec_err[15:12]};
         // unmapped addresses read zero
         default:       rmux = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      // pulses drop, the rest holds
      nxt_s = s_ff;
      nxt_s.rvld = req.rd;
      nxt_s.go   = 1'b0;
      nxt_s.blkd = 1'b0;
      if (req.rd) begin
         nxt_s.rdat = rmux;
      end
      // otp lock strap caught on the first cycle after power-up
      // a same-cycle config write still sets it
      if (s_ff.init) begin
         nxt_s.otp_lock = otp_locked;
         nxt_s.init     = 1'b0;
      end
      // writes: status and sector registers ignore them
      // protect register when lock rules allow
      if (req.wr && req.adr == `NFR_ADR_PROTECT && prot_wr_ok) begin
         nxt_s.lock_write_protect_bit = req.wdat[`NFR_PR_LOCKWP];
         nxt_s.block_protect_code =
            req.wdat[`NFR_PR_BP_HI:`NFR_PR_BP_LO];
         nxt_s.top_bottom_select = req.wdat[`NFR_PR_TB];
         nxt_s.power_lock_bit    = req.wdat[`NFR_PR_PLOCK];
      end
      // otp lock only sets; or into the next
      // value keeps a strap caught this cycle
      if (req.wr && req.adr == `NFR_ADR_CONFIG) begin
         nxt_s.otp_lock = nxt_s.otp_lock | req.wdat[`NFR_CF_OTPL];
         nxt_s.otp_en   = req.wdat[`NFR_CF_OTPE];
         nxt_s.ecc_en   = req.wdat[`NFR_CF_ECCE];
         nxt_s.drive_strength_field =
            req.wdat[`NFR_CF_DRV_HI:`NFR_CF_DRV_LO];
         nxt_s.quad_enable_bit = req.wdat[`NFR_CF_QE];
      end
      // write enable latch
      // a clear wins over a set
      if (ev.wr_dis || ev.prog || ev.erase || ev.page_rd) begin
         nxt_s.write_enable_latch = 1'b0;
      end else if (ev.wr_en) begin
         nxt_s.write_enable_latch = 1'b1;
      end
      // program/erase: fail flags cleared at start, checked next
      if (ev.prog || ev.erase) begin
         nxt_s.pfail   = 1'b0;
         nxt_s.efail   = 1'b0;
         nxt_s.pend    = 1'b1;
         nxt_s.pend_pg = ev.prog;
      end
      // decode of the pending op ready;
      // a refused op flags its own kind
      if (s_ff.pend) begin
         nxt_s.pend = 1'b0;
         if (blk_prot) begin
            nxt_s.blkd = 1'b1;
            if (s_ff.pend_pg) begin
               nxt_s.pfail = 1'b1;
            end else begin
               nxt_s.efail = 1'b1;
            end
         end else begin
            nxt_s.go = 1'b1;
         end
      end
      // array failures set the flags;
      // after the clears, so a set wins
      if (ev.pfail) begin
         nxt_s.pfail = 1'b1;
      end
      if (ev.efail) begin
         nxt_s.efail = 1'b1;
      end
      // last page read ecc result; the
      // first after power-up is page zero
      if (ev.ecc_vld) begin
         nxt_s.ecc_result_bits = ev.ecc_sum;
         nxt_s.sec_err         = ev.ecc_sec;
      end
      // soft reset: status only, settings kept
      // last, so it wins over events;
      // otp access is config, kept
      if (ev.soft_rst) begin
         nxt_s.ecc_result_bits    = 2'b00;
         nxt_s.pfail              = 1'b0;
         nxt_s.efail              = 1'b0;
         nxt_s.write_enable_latch = 1'b0;
         nxt_s.sec_err            = 16'h0000;
         nxt_s.pend               = 1'b0;
         nxt_s.blkd               = 1'b0;
         nxt_s.go                 = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state register; rst models a power cycle
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         // power cycle drops both lock bits
         s_ff                        <= '0;
         s_ff.block_protect_code     <= `NFR_RST_BP;
         s_ff.top_bottom_select      <= `NFR_RST_TB;
         s_ff.ecc_en                 <= `NFR_RST_ECCE;
         s_ff.drive_strength_field   <= `NFR_RST_DRV;
         // strap caught a cycle later
         s_ff.init                   <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   // read answer a cycle after strobe
   assign rd_data    = s_ff.rdat;
   assign rd_vld     = s_ff.rvld;
   assign op_go      = s_ff.go;
   assign op_block   = s_ff.blkd;
   // levels for pads and array
   assign quad_mode  = s_ff.quad_enable_bit;
   assign drive_sel  = s_ff.drive_strength_field;
   assign ecc_on     = s_ff.ecc_en;
   assign otp_access = s_ff.otp_en;

endmodule : nfr_feature_regs

// [src/nfr_srst_timer.sv]
// Purpose: busy timer started by a soft reset command
// Assumes: start is a one-cycle pulse on mclk
// Notes:   busy is high from the cycle after start until the count ends
`include "nfr_defines.svh"
module nfr_srst_timer
   import nfr_pkg::*;
(
   input  wire logic mclk,  // system clock
   input  wire logic rst,   // sync reset
   input  wire logic start, // soft reset pulse
   output logic      busy   // timer running
);

   nfr_srst_state_type s_ff;   // timer state
   nfr_srst_state_type nxt_s;  // next state

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      case (s_ff.st)
         NFR_IDLE: begin
            if (start) begin
               nxt_s.st  = NFR_BUSY;
               nxt_s.cnt = 8'(`NFR_SRST_CYC - 1);
            end
         end
         NFR_BUSY: begin
            if (start) begin // restart on a new reset
               nxt_s.cnt = 8'(`NFR_SRST_CYC - 1);
            end else if (s_ff.cnt == 8'h00) begin
               nxt_s.st = NFR_IDLE;
            end else begin
               nxt_s.cnt = s_ff.cnt - 8'h01;
            end
         end
         default: nxt_s = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign busy = (s_ff.st == NFR_BUSY);

endmodule : nfr_srst_timer

// [testbench/nfr_feature_regs_props.sv]
// Purpose: port checks of the feature register bank
// Assumes: one clock domain, rst active high
// Notes:   latencies follow the hand-over contract
module nfr_feature_regs_props
   import nfr_pkg::*;
(
   input wire logic             mclk,
   input wire logic             rst,
   input wire nfr_feat_req_type req,
   input wire nfr_core_ev_type  ev,
   input wire logic             rd_vld,
   input wire logic [7:0]       rd_data,
   input wire logic             op_go,
   input wire logic             op_block,
   input wire logic             quad_mode,
   input wire logic [1:0]       drive_sel,
   input wire logic             ecc_on,
   input wire logic             otp_access
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // op pulse not cancelled by a soft reset
   sequence s_op;
      (ev.prog || ev.erase) && !ev.soft_rst ##1 !ev.soft_rst;
   endsequence
   // soft reset with no write for three cycles
   sequence s_srst;
      ev.soft_rst && !req.wr ##1 !req.wr [*2];
   endsequence
   property p_rd_lat; req.rd |=> rd_vld; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("late read");
   property p_rd_idle; !req.rd |=> !rd_vld; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read");
   property p_rd_hold; !req.rd |=> $stable(rd_data); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("data moved");
   property p_op_lat; s_op |=> (op_go != op_block); endproperty
   a_op_lat: assert property (p_op_lat) else $error("no op answer");
   property p_op_src;
      (op_go || op_block) |-> $past(ev.prog || ev.erase, 2);
   endproperty
   a_op_src: assert property (p_op_src) else $error("stray op");
   property p_pwr;
      $fell(rst) |-> !quad_mode && drive_sel == 2'h0 && ecc_on && !otp_access;
   endproperty
   a_pwr: assert property (p_pwr) else $error("bad power-up");
   property p_keep;
      ev.soft_rst && !req.wr |=> $stable(drive_sel) && $stable(ecc_on);
   endproperty
   a_keep: assert property (p_keep) else $error("config lost");
   property p_otp; s_srst |-> otp_access == $past(otp_access, 2); endproperty
   a_otp: assert property (p_otp) else $error("otp mode lost");
endmodule : nfr_feature_regs_props

bind nfr_feature_regs nfr_feature_regs_props chk_u (.mclk(mclk), .rst(rst),
   .req(req), .ev(ev), .rd_vld(rd_vld), .rd_data(rd_data), .op_go(op_go),
   .op_block(op_block), .quad_mode(quad_mode), .drive_sel(drive_sel),
   .ecc_on(ecc_on), .otp_access(otp_access));

// [testbench/nfr_host_model.sv]
// Purpose: host issuing read- and write-feature requests
// Assumes: caller waits for each task to return
// Notes:   released lines show inverted values, never the last one
module nfr_host_model
   import nfr_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_vld,
   output nfr_feat_req_type req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   task tick; @(posedge mclk); #1; endtask : tick
   // one address byte, answer taken one edge later
   task feat_rd(input logic [7:0] a, output logic [7:0] d);
      tick; req.rd = 1'b1; req.adr = a;
      tick; req.rd = 1'b0; req.adr = ~a;
      d = (rd_vld === 1'b1) ? rd_data : 8'hxx;
   endtask : feat_rd
   // one address byte and one data byte
   task feat_wr(input logic [7:0] a, input logic [7:0] w);
      tick; req.wr = 1'b1; req.adr = a; req.wdat = w;
      tick; req.wr = 1'b0; req.adr = ~a; req.wdat = ~w;
   endtask : feat_wr
endmodule : nfr_host_model

// [testbench/tb_top.sv]
// Purpose: self-checking bench of the feature register bank
// Assumes: host model drives req, bench drives core events
// Notes:   random protect values and targets, seed 82
`include "nfr_defines.svh"
module tb_top
   import nfr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, otp_locked, wp_n, rd_vld, op_go, op_block;
   logic quad_mode, ecc_on, otp_access;
   logic [1:0] drive_sel;
   logic [7:0] rd_data, d;
   logic [10:0] tgt_blk;
   nfr_feat_req_type req;
   nfr_core_ev_type ev;
   int fails, comparisons, cyc, seed, i, k, n;
   nfr_feature_regs dut_u (.mclk(mclk), .rst(rst), .req(req), .ev(ev),
      .tgt_blk(tgt_blk), .otp_locked(otp_locked), .wp_n(wp_n),
      .rd_data(rd_data), .rd_vld(rd_vld), .op_go(op_go),
      .op_block(op_block), .quad_mode(quad_mode), .drive_sel(drive_sel),
      .ecc_on(ecc_on), .otp_access(otp_access));
   nfr_host_model host_u (.mclk(mclk), .rd_data(rd_data), .rd_vld(rd_vld),
      .req(req));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task stop_test;
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task tick; @(posedge mclk); #1; endtask : tick
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host_u.feat_rd(a, d);
      chk($sformatf("feature %h", a), exp, d);
   endtask : rd_chk
   // expected protection of one block
   function automatic logic pexp(logic [3:0] c, logic t, logic [10:0] b);
      int m;
      m = 1 << (c - 4'h1);
      if (c == 4'h0) return 1'b0;
      if (c[3:2] == 2'b11) return 1'b1;
      return t ? (b < m) : (b >= 2048 - m);
   endfunction : pexp
   // set protect code, issue program or erase, check verdict and flags
   task op(logic [3:0] c, logic t, logic [10:0] b, logic er);
      logic p;
      p = pexp(c, t, b);
      host_u.feat_wr(`NFR_ADR_PROTECT, {1'b0, c, t, 2'b00});
      tick; tgt_blk = b; ev.prog = !er; ev.erase = er;
      tick; ev.prog = 1'b0; ev.erase = 1'b0;
      tick; chk("op_block", {7'h0, p}, {7'h0, op_block});
      chk("op_go", {7'h0, !p}, {7'h0, op_go});
      rd_chk(`NFR_ADR_STATUS, {4'h1, p & !er, p & er, 2'b00});
   endtask : op
   initial begin
      seed = 82;
      rst = 1'b1; ev = '0; tgt_blk = '0; otp_locked = 1'b0; wp_n = 1'b1;
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      rd_chk(`NFR_ADR_PROTECT, 8'h7c);
      rd_chk(`NFR_ADR_CONFIG, 8'h10);
      // page zero ecc result arrives after power-up
      ev.ecc_sum = 2'b01; ev.ecc_sec = 16'h2010; ev.ecc_vld = 1'b1;
      tick; ev.ecc_vld = 1'b0; ev.wr_en = 1'b1;
      tick; ev.wr_en = 1'b0;
      rd_chk(`NFR_ADR_STATUS, 8'h12);
      for (k = 0; k < 4; k++) begin
         rd_chk(8'(8'h80 + 4 * k),
                {2'b00, 2'(k), ev.ecc_sec[4*k+:4]});
      end
      host_u.feat_wr(`NFR_ADR_STATUS, 8'hff);
      host_u.feat_wr(`NFR_ADR_SEC1, 8'h00);
      rd_chk(`NFR_ADR_STATUS, 8'h12);
      rd_chk(`NFR_ADR_SEC1, 8'h11);
      rd_chk(8'h90, 8'h00);
      ev.wr_dis = 1'b1;
      tick;
      ev.wr_dis = 1'b0;
      rd_chk(`NFR_ADR_STATUS, 8'h10);
      for (i = 0; i < 4; i++) begin
         d = 8'($random(seed)) & 8'h7c;
         host_u.feat_wr(`NFR_ADR_PROTECT, d);
         rd_chk(`NFR_ADR_PROTECT, d & 8'h7c);
      end
      for (k = 0; k < 32; k++) begin
         op(4'(k), k[4], 11'($random(seed)), k[0]);
      end
      // edges of every partial region
      for (k = 1; k < 12; k++) begin
         n = 1 << (k - 1);
         op(4'(k), 1'b0, 11'(2048 - n), 1'b0);
         op(4'(k), 1'b0, 11'(2047 - n), 1'b1);
         op(4'(k), 1'b1, 11'(n - 1), 1'b0);
         op(4'(k), 1'b1, 11'(n), 1'b1);
      end
      // pin lock, quad override, power lock
      host_u.feat_wr(`NFR_ADR_PROTECT, 8'h80);
      wp_n = 1'b0;
      repeat (3) tick;
      host_u.feat_wr(`NFR_ADR_PROTECT, 8'h7c);
      rd_chk(`NFR_ADR_PROTECT, 8'h80);
      wp_n = 1'b1;
      repeat (3) tick;
      host_u.feat_wr(`NFR_ADR_PROTECT, 8'h84);
      rd_chk(`NFR_ADR_PROTECT, 8'h84);
      wp_n = 1'b0;
      host_u.feat_wr(`NFR_ADR_CONFIG, 8'h55);
      host_u.feat_wr(`NFR_ADR_PROTECT, 8'h88);
      rd_chk(`NFR_ADR_PROTECT, 8'h88);
      chk("config pins", 8'h1e,
          {3'h0, otp_access, ecc_on, quad_mode, drive_sel});
      ev.wr_en = 1'b1;
      tick;
      ev.wr_en = 1'b0;
      rd_chk(`NFR_ADR_STATUS, 8'h12);
      ev.soft_rst = 1'b1;
      tick;
      ev.soft_rst = 1'b0;
      host_u.feat_rd(`NFR_ADR_STATUS, d);
      chk("busy", 8'h01, d);
      repeat (12) tick;
      rd_chk(`NFR_ADR_STATUS, 8'h00);
      rd_chk(`NFR_ADR_SEC3, 8'h30);
      rd_chk(`NFR_ADR_PROTECT, 8'h88);
      rd_chk(`NFR_ADR_CONFIG, 8'h55);
      host_u.feat_wr(`NFR_ADR_PROTECT, 8'h89);
      host_u.feat_wr(`NFR_ADR_PROTECT, 8'h00);
      rd_chk(`NFR_ADR_PROTECT, 8'h89);
      otp_locked = 1'b1; rst = 1'b1;
      repeat (2) tick;
      rst = 1'b0;
      rd_chk(`NFR_ADR_PROTECT, 8'h7c);
      rd_chk(`NFR_ADR_CONFIG, 8'h90);
      stop_test();
   end
endmodule : tb_top
